/* File: tlx_exec.sv */
// timer load, status test and accumulator and/or execute unit
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - and with register: acc gets acc and reg, carry gets both bit 3s
// - table operands fetch the word at page register joined with pointer pair
// - high variant uses table bits 7:4, low variant uses bits 3:0
// - table and: carry is acc bit 3 and table bit 7 or bit 3
// - immediate and uses second word low nibble, carry from both bit 3s
// - or with register: acc gets acc or reg, carry cleared
// - table or: acc or selected table nibble, carry cleared
// - immediate or: acc or second word nibble, carry cleared
// - timer and modulo registers load 10 bits from table or immediate word
// - status test sets test flag on match with immediate or register
// - upper table address bits come from page register, lower from pointer pair
// - program words are 10 bits; nibble operations ignore top two bits
module tlx_exec
  import tlx_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic [9:0] instr_second,
  // program memory table port
  output logic [ADDR_W-1:0] table_addr,
  input wire logic [9:0] table_word,
  // device status compared by the status test
  input wire logic [3:0] device_status,
  // execution results
  output logic exec_done_q,
  output logic [1:0] exec_len_q,
  output logic carry_flag_q,
  output logic test_flag_q,
  output logic [3:0] acc_q,
  output logic [9:0] timer_q,
  output logic [9:0] modulo_reg_a_q,
  output logic [9:0] modulo_reg_b_q,
  // register port
  input wire logic [5:0] reg_addr,
  input wire logic [9:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [9:0] reg_rdata_q
);

  localparam int PAGE_W = ADDR_W - 8;

  if (ADDR_W < 10 || ADDR_W > 12) begin : g_addr_check
    $error("tlx_exec: ADDR_W must lie between 10 and 12");
  end

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [3:0] work_q [32];
  logic [3:0] rom_page_control_q;
  logic [7:0] table_pointer_pair_q;
  logic illegal_q;

  //////////////////////////////////////////////////////////////////////////////
  // decode
  logic [3:0] grp;
  logic [4:0] low5;
  logic [4:0] reg_sel;
  logic [3:0] reg_val;
  logic [3:0] tab_nib;
  logic [3:0] imm_nib;
  logic is_reg_form;
  logic is_tab_form;
  logic is_imm_form;

  assign grp = instr_word[9:6];
  assign low5 = instr_word[4:0];
  // bank bit set selects the first register bank
  assign reg_sel = {~instr_word[HILO_BIT], instr_word[3:0]};
  assign reg_val = work_q[reg_sel];
  assign is_reg_form = ~instr_word[REGFORM_BIT];
  assign is_tab_form = (low5 == LOW_TABLE);
  assign is_imm_form = (low5 == LOW_IMM) && instr_word[HILO_BIT];

  // table address: page bits on top of the pointer pair
  assign table_addr = {rom_page_control_q[PAGE_W-1:0], table_pointer_pair_q};

  // high variant has the select bit clear
  assign tab_nib = instr_word[HILO_BIT] ? table_word[3:0] : table_word[7:4];
  assign imm_nib = instr_second[3:0];

  //////////////////////////////////////////////////////////////////////////////
  // execute, combinational next values
  logic [3:0] acc_d;
  logic carry_d;
  logic test_d;
  logic [9:0] timer_d;
  logic [9:0] mod_a_d;
  logic [9:0] mod_b_d;
  logic [1:0] len_d;
  logic legal_d;

  always_comb begin
    acc_d = acc_q;
    carry_d = carry_flag_q;
    test_d = test_flag_q;
    timer_d = timer_q;
    mod_a_d = modulo_reg_a_q;
    mod_b_d = modulo_reg_b_q;
    len_d = LEN_ONE;
    legal_d = 1'b1;
    if (grp == GRP_AND && is_reg_form) begin
      acc_d = acc_q & reg_val;
      carry_d = acc_q[3] & reg_val[3];
    end else if (grp == GRP_AND && is_tab_form) begin
      acc_d = acc_q & tab_nib;
      carry_d = acc_q[3] & tab_nib[3];
    end else if (grp == GRP_AND && is_imm_form) begin
      acc_d = acc_q & imm_nib;
      carry_d = acc_q[3] & imm_nib[3];
      len_d = LEN_TWO;
    end else if (grp == GRP_OR && is_reg_form) begin
      acc_d = acc_q | reg_val;
      carry_d = 1'b0;
    end else if (grp == GRP_OR && is_tab_form) begin
      acc_d = acc_q | tab_nib;
      carry_d = 1'b0;
    end else if (grp == GRP_OR && is_imm_form) begin
      acc_d = acc_q | imm_nib;
      carry_d = 1'b0;
      len_d = LEN_TWO;
    end else if (instr_word[9:4] == OP_STATUS_TEST_OP_REG[9:4]) begin
      test_d = (device_status == work_q[{1'b0, instr_word[3:0]}]);
    end else begin
      unique case (instr_word)
        OP_NOP: ;
        OP_CARRY_SET_IF_ALL_ONES_OP: carry_d = (acc_q == 4'hf);
        OP_STATUS_TEST_OP_IMM: begin
          test_d = (device_status == imm_nib);
          len_d = LEN_TWO;
        end
        OP_LD_T_IMM: begin
          timer_d = instr_second;
          len_d = LEN_TWO;
        end
        OP_LD_MA_IMM: begin
          mod_a_d = instr_second;
          len_d = LEN_TWO;
        end
        OP_LD_MB_IMM: begin
          mod_b_d = instr_second;
          len_d = LEN_TWO;
        end
        OP_LD_T_TAB: timer_d = table_word;
        OP_LD_MA_TAB: mod_a_d = table_word;
        OP_LD_MB_TAB: mod_b_d = table_word;
        OP_A_FROM_T0: {carry_d, acc_d} = {1'b0, timer_q[3:0]};
        OP_A_FROM_T1: {carry_d, acc_d} = {1'b0, timer_q[7:4]};
        OP_A_FROM_MA0: {carry_d, acc_d} = {1'b0, modulo_reg_a_q[3:0]};
        OP_A_FROM_MA1: {carry_d, acc_d} = {1'b0, modulo_reg_a_q[7:4]};
        OP_A_FROM_MB0: {carry_d, acc_d} = {1'b0, modulo_reg_b_q[3:0]};
        OP_A_FROM_MB1: {carry_d, acc_d} = {1'b0, modulo_reg_b_q[7:4]};
        OP_T0_FROM_A: begin
          timer_d[3:0] = acc_q;
          carry_d = 1'b0;
        end
        OP_T1_FROM_A: begin
          timer_d[7:4] = acc_q;
          carry_d = 1'b0;
        end
        OP_MA0_FROM_A: begin
          mod_a_d[3:0] = acc_q;
          carry_d = 1'b0;
        end
        OP_MA1_FROM_A: begin
          mod_a_d[7:4] = acc_q;
          carry_d = 1'b0;
        end
        OP_MB0_FROM_A: begin
          mod_b_d[3:0] = acc_q;
          carry_d = 1'b0;
        end
        OP_MB1_FROM_A: begin
          mod_b_d[7:4] = acc_q;
          carry_d = 1'b0;
        end
        default: legal_d = 1'b0;
      endcase
    end
  end

  logic exec_ok;
  assign exec_ok = instr_valid && legal_d;

  //////////////////////////////////////////////////////////////////////////////
  // accumulator and flags; an executing instruction wins over a port write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q <= ACC_RST;
    end else if (exec_ok) begin
      acc_q <= acc_d;
    end else if (reg_wr && reg_addr == REG_ACC) begin
      acc_q <= reg_wdata[3:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      carry_flag_q <= 1'b0;
      test_flag_q <= 1'b0;
    end else if (exec_ok) begin
      carry_flag_q <= carry_d;
      test_flag_q <= test_d;
    end else if (reg_wr && reg_addr == REG_FLAGS) begin
      carry_flag_q <= reg_wdata[FLAG_CARRY_BIT];
      test_flag_q <= reg_wdata[FLAG_TEST_BIT];
    end
  end

  // sticky: a new illegal code beats a clearing write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      illegal_q <= 1'b0;
    end else if (instr_valid && !legal_d) begin
      illegal_q <= 1'b1;
    end else if (reg_wr && reg_addr == REG_FLAGS && reg_wdata[FLAG_ILLEGAL_BIT]) begin
      illegal_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // timer and modulo registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timer_q <= WORD_RST;
      modulo_reg_a_q <= WORD_RST;
      modulo_reg_b_q <= WORD_RST;
    end else if (exec_ok) begin
      timer_q <= timer_d;
      modulo_reg_a_q <= mod_a_d;
      modulo_reg_b_q <= mod_b_d;
    end else if (reg_wr) begin
      if (reg_addr == REG_TIMER) begin
        timer_q <= reg_wdata;
      end
      if (reg_addr == REG_MOD_A) begin
        modulo_reg_a_q <= reg_wdata;
      end
      if (reg_addr == REG_MOD_B) begin
        modulo_reg_b_q <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // completion report, one cycle after issue
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      exec_done_q <= 1'b0;
      exec_len_q <= LEN_ONE;
    end else begin
      exec_done_q <= exec_ok;
      if (exec_ok) begin
        exec_len_q <= len_d;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software-only registers: working nibbles, page control, pointer pair
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rom_page_control_q <= PAGE_RST;
      table_pointer_pair_q <= PTR_RST;
    end else if (reg_wr) begin
      if (reg_addr == REG_PAGE) begin
        rom_page_control_q <= reg_wdata[3:0];
      end
      if (reg_addr == REG_PTR) begin
        table_pointer_pair_q <= reg_wdata[7:0];
      end
    end
  end

  for (genvar i = 0; i < 32; i++) begin : g_work
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        work_q[i] <= ACC_RST;
      end else if (reg_wr && reg_addr == REG_WORK_BASE + 6'(i)) begin
        work_q[i] <= reg_wdata[3:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path
  logic [9:0] rdata_d;

  always_comb begin
    rdata_d = 10'h000;
    if (reg_addr < REG_ACC) begin
      rdata_d = {6'h00, work_q[reg_addr[4:0]]};
    end else begin
      unique case (reg_addr)
        REG_ACC: rdata_d = {6'h00, acc_q};
        REG_FLAGS: rdata_d = {7'h00, illegal_q, test_flag_q, carry_flag_q};
        REG_TIMER: rdata_d = timer_q;
        REG_MOD_A: rdata_d = modulo_reg_a_q;
        REG_MOD_B: rdata_d = modulo_reg_b_q;
        REG_PAGE: rdata_d = {6'h00, rom_page_control_q};
        REG_PTR: rdata_d = {2'h0, table_pointer_pair_q};
        default: rdata_d = 10'h000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 10'h000;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= 10'h000;
    end
  end

endmodule : tlx_exec

/* File: tlx_pkg.sv */
// constants for the timer and logic-op execute block
package tlx_pkg;

  // instruction codes, 10-bit words
  localparam logic [9:0] OP_NOP = 10'h000;
  localparam logic [9:0] OP_CARRY_SET_IF_ALL_ONES_OP = 10'h353;
  localparam logic [9:0] OP_STATUS_TEST_OP_IMM = 10'h071;
  localparam logic [9:0] OP_STATUS_TEST_OP_REG = 10'h060;
  localparam logic [9:0] OP_LD_T_IMM = 10'h0df;
  localparam logic [9:0] OP_LD_MA_IMM = 10'h0d6;
  localparam logic [9:0] OP_LD_MB_IMM = 10'h0d7;
  localparam logic [9:0] OP_LD_T_TAB = 10'h29f;
  localparam logic [9:0] OP_LD_MA_TAB = 10'h0f6;
  localparam logic [9:0] OP_LD_MB_TAB = 10'h0f7;
  localparam logic [9:0] OP_A_FROM_T0 = 10'h3ff;
  localparam logic [9:0] OP_A_FROM_T1 = 10'h3df;
  localparam logic [9:0] OP_A_FROM_MA0 = 10'h3f6;
  localparam logic [9:0] OP_A_FROM_MA1 = 10'h3d6;
  localparam logic [9:0] OP_A_FROM_MB0 = 10'h3f7;
  localparam logic [9:0] OP_A_FROM_MB1 = 10'h3d7;
  localparam logic [9:0] OP_T0_FROM_A = 10'h0bf;
  localparam logic [9:0] OP_T1_FROM_A = 10'h09f;
  localparam logic [9:0] OP_MA0_FROM_A = 10'h0b6;
  localparam logic [9:0] OP_MA1_FROM_A = 10'h096;
  localparam logic [9:0] OP_MB0_FROM_A = 10'h0b7;
  localparam logic [9:0] OP_MB1_FROM_A = 10'h097;
  // group prefixes in bits 9:6 and low-field shapes
  localparam logic [3:0] GRP_AND = 4'hd;
  localparam logic [3:0] GRP_OR = 4'he;
  localparam logic [4:0] LOW_TABLE = 5'h10;
  localparam logic [4:0] LOW_IMM = 5'h11;
  localparam int HILO_BIT = 5;
  localparam int REGFORM_BIT = 4;

  // register map, word addresses on the register port
  localparam logic [5:0] REG_WORK_BASE = 6'h00;
  localparam logic [5:0] REG_ACC = 6'h20;
  localparam logic [5:0] REG_FLAGS = 6'h21;
  localparam logic [5:0] REG_TIMER = 6'h22;
  localparam logic [5:0] REG_MOD_A = 6'h23;
  localparam logic [5:0] REG_MOD_B = 6'h24;
  localparam logic [5:0] REG_PAGE = 6'h25;
  localparam logic [5:0] REG_PTR = 6'h26;
  // flags register fields
  localparam int FLAG_CARRY_BIT = 0;
  localparam int FLAG_TEST_BIT = 1;
  localparam int FLAG_ILLEGAL_BIT = 2;

  // reset values
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [9:0] WORD_RST = 10'h000;
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic [7:0] PTR_RST = 8'h00;

  // instruction lengths reported back to the fetch side
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;

endpackage : tlx_pkg

/* File: tlx_rom_model.sv */
// program memory model answering table reads
`timescale 1ns/1ps
module tlx_rom_model #(
  parameter int ADDR_W = 11
) (
  // table port
  input wire logic [ADDR_W-1:0] table_addr,
  output logic [9:0] table_word
);
  // same-cycle read of a full 10-bit word
  assign table_word = 10'(table_addr * 37) ^ 10'h2b5;
endmodule : tlx_rom_model

/* File: tlx_exec_sva.sv */
// port assertions for the execute unit
`timescale 1ns/1ps
module tlx_exec_chk
  import tlx_pkg::*;
#(
  parameter int ADDR_W = 11
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // instruction side
  input wire logic instr_valid,
  input wire logic [9:0] instr_word,
  input wire logic [9:0] instr_second,
  input wire logic [9:0] table_word,
  input wire logic [3:0] device_status,
  // results
  input wire logic exec_done_q,
  input wire logic [1:0] exec_len_q,
  input wire logic carry_flag_q,
  input wire logic test_flag_q,
  input wire logic [3:0] acc_q,
  input wire logic [9:0] timer_q,
  input wire logic [9:0] modulo_reg_a_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_issue(logic [9:0] op);
    instr_valid && instr_word == op;
  endsequence
  ////////////////////////////////////////
  chk_and_tab_hi: assert property (s_issue(10'h350) |=>
    acc_q == ($past(acc_q) & $past(table_word[7:4])) && carry_flag_q == ($past(acc_q[3]) & $past(table_word[7])))
    else $error("table and high wrong");
  chk_or_tab_lo: assert property (s_issue(10'h3b0) |=>
    acc_q == ($past(acc_q) | $past(table_word[3:0])) && !carry_flag_q) else $error("table or low wrong");
  chk_and_imm: assert property (s_issue(10'h371) |=>
    acc_q == ($past(acc_q) & $past(instr_second[3:0])) && carry_flag_q == ($past(acc_q[3]) & $past(instr_second[3])))
    else $error("immediate and wrong");
  chk_or_imm: assert property (s_issue(10'h3b1) |=>
    acc_q == ($past(acc_q) | $past(instr_second[3:0])) && !carry_flag_q) else $error("immediate or wrong");
  chk_timer_load: assert property (s_issue(OP_LD_T_IMM) |=>
    timer_q == $past(instr_second) && exec_len_q == LEN_TWO) else $error("timer load wrong");
  chk_mod_tab_load: assert property (s_issue(OP_LD_MA_TAB) |=>
    modulo_reg_a_q == $past(table_word)) else $error("modulo table load wrong");
  chk_status_test: assert property (s_issue(OP_STATUS_TEST_OP_IMM) |=>
    test_flag_q == ($past(device_status) == $past(instr_second[3:0]))) else $error("status test wrong");
  chk_all_ones: assert property (s_issue(OP_CARRY_SET_IF_ALL_ONES_OP) |=> carry_flag_q == ($past(acc_q) == 4'hf))
    else $error("carry all ones wrong");
  chk_nibble_move: assert property (s_issue(OP_A_FROM_T1) |=>
    acc_q == $past(timer_q[7:4]) && !carry_flag_q) else $error("nibble move wrong");
  chk_noop_len: assert property (s_issue(OP_NOP) |=> exec_done_q && exec_len_q == LEN_ONE)
    else $error("no-op done wrong");
  chk_done_cause: assert property (exec_done_q |-> $past(instr_valid))
    else $error("done without issue");
endmodule : tlx_exec_chk

bind tlx_exec tlx_exec_chk #(.ADDR_W(ADDR_W)) i_chk (.core_clk(core_clk), .reset_n(reset_n),
  .instr_valid(instr_valid), .instr_word(instr_word), .instr_second(instr_second), .table_word(table_word),
  .device_status(device_status), .exec_done_q(exec_done_q), .exec_len_q(exec_len_q),
  .carry_flag_q(carry_flag_q), .test_flag_q(test_flag_q), .acc_q(acc_q), .timer_q(timer_q),
  .modulo_reg_a_q(modulo_reg_a_q));

/* File: tb_top.sv */
// self-checking bench for the execute unit
`timescale 1ns/1ps
module tb_top;
  import tlx_pkg::*;
  localparam int AW = 11;
  localparam logic [9:0] ILL = 10'h3e0;
  logic core_clk = 0, reset_n = 0, instr_valid = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0;
  logic [9:0] instr_word = 0, instr_second = 0, reg_wdata = 0;
  logic [5:0] reg_addr = 0;
  logic [3:0] device_status = 0;
  logic exec_done_q, carry_flag_q, test_flag_q;
  logic [1:0] exec_len_q;
  logic [3:0] acc_q;
  logic [9:0] table_word, reg_rdata_q, timer_q, modulo_reg_a_q, modulo_reg_b_q;
  logic [AW-1:0] table_addr;
  logic [3:0] acc = 0, pg = 0;
  logic [9:0] tm = 0, ma = 0, mb = 0;
  logic [7:0] pt = 0;
  logic cy = 0, tf = 0;
  logic [3:0] wr [32];
  logic [37:0] exp_q [$], rd_q [$], obs;
  logic [9:0] tab [4] = '{10'h350, 10'h370, 10'h390, 10'h3b0};
  logic [9:0] mv [18] = '{OP_LD_T_IMM, OP_LD_MA_IMM, OP_LD_MB_IMM, OP_LD_T_TAB, OP_LD_MA_TAB, OP_LD_MB_TAB,
    OP_A_FROM_T0, OP_A_FROM_T1, OP_A_FROM_MA0, OP_A_FROM_MA1, OP_A_FROM_MB0, OP_A_FROM_MB1,
    OP_T0_FROM_A, OP_T1_FROM_A, OP_MA0_FROM_A, OP_MA1_FROM_A, OP_MB0_FROM_A, OP_MB1_FROM_A};
  int errors = 0;
  int n_compared = 0;
  always #50 core_clk = ~core_clk;
  assign obs = {exec_len_q, acc_q, carry_flag_q, test_flag_q, timer_q, modulo_reg_a_q, modulo_reg_b_q};
  tlx_exec #(.ADDR_W(AW)) i_dut (.core_clk(core_clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_second(instr_second), .table_addr(table_addr), .table_word(table_word),
    .device_status(device_status), .exec_done_q(exec_done_q), .exec_len_q(exec_len_q),
    .carry_flag_q(carry_flag_q), .test_flag_q(test_flag_q), .acc_q(acc_q), .timer_q(timer_q),
    .modulo_reg_a_q(modulo_reg_a_q), .modulo_reg_b_q(modulo_reg_b_q), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
  tlx_rom_model #(.ADDR_W(AW)) i_rom (.table_addr(table_addr), .table_word(table_word));
  ////////////////////////////////////////
  task automatic check(input logic [37:0] seen, input logic [37:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : check
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic wrt(input logic [5:0] a, input logic [9:0] d);
    @(posedge core_clk);
    {instr_valid, reg_rd, reg_wr, reg_addr, reg_wdata} <= {3'b001, a, d};
    if (a < 6'h20) wr[a[4:0]] = d[3:0];
    if (a == REG_ACC) acc = d[3:0];
    if (a == REG_PAGE) pg = d[3:0];
    if (a == REG_PTR) pt = d[7:0];
    if (a == REG_FLAGS) {tf, cy} = d[1:0];
    if (a == REG_TIMER) tm = d;
    if (a == REG_MOD_A) ma = d;
    if (a == REG_MOD_B) mb = d;
  endtask : wrt
  task automatic rd(input logic [5:0] a, input logic [9:0] e);
    @(posedge core_clk);
    {instr_valid, reg_rd, reg_wr, reg_addr} <= {3'b010, a};
    rd_q.push_back(38'(e));
  endtask : rd
  task automatic run(input logic [9:0] w, input logic [9:0] s, input logic [3:0] ds);
    logic [9:0] t;
    logic [9:0] nv;
    logic [3:0] op;
    logic [1:0] ln;
    @(posedge core_clk);
    {instr_valid, reg_rd, reg_wr, instr_word, instr_second, device_status} <= {3'b100, w, s, ds};
    t = 10'({pg[AW-9:0], pt} * 37) ^ 10'h2b5;
    op = w[4] ? (w[0] ? s[3:0] : w[5] ? t[3:0] : t[7:4]) : wr[{~w[5], w[3:0]}];
    ln = w inside {10'h371, 10'h3b1, OP_STATUS_TEST_OP_IMM, OP_LD_T_IMM, OP_LD_MA_IMM, OP_LD_MB_IMM} ? LEN_TWO : LEN_ONE;
    nv = w[4:0] == 5'h1f ? tm : w[0] ? mb : ma;
    case (w)
      ILL, OP_NOP: ;
      OP_CARRY_SET_IF_ALL_ONES_OP: cy = acc == 4'hf;
      OP_STATUS_TEST_OP_IMM: tf = ds == s[3:0];
      OP_LD_T_IMM: tm = s;
      OP_LD_MA_IMM: ma = s;
      OP_LD_MB_IMM: mb = s;
      OP_LD_T_TAB: tm = t;
      OP_LD_MA_TAB: ma = t;
      OP_LD_MB_TAB: mb = t;
      default: begin
        if (w[9:4] == 6'h06) tf = ds == wr[w[3:0]];
        else if (w[9:6] == GRP_AND) {cy, acc} = {acc[3] & op[3], acc & op};
        else if (w[9:6] == GRP_OR) {cy, acc} = {1'b0, acc | op};
        else if (w[9]) {cy, acc} = {1'b0, w[5] ? nv[3:0] : nv[7:4]};
        else begin
          cy = 1'b0;
          if (w[5]) nv[3:0] = acc;
          else nv[7:4] = acc;
          if (w[4:0] == 5'h1f) tm = nv;
          else if (w[0]) mb = nv;
          else ma = nv;
        end
      end
    endcase
    if (w != ILL) exp_q.push_back({ln, acc, cy, tf, tm, ma, mb});
  endtask : run
  ////////////////////////////////////////
  always @(posedge core_clk) rd_seen <= reg_rd;
  always @(negedge core_clk) begin
    if (exec_done_q === 1'b1) check(obs, exp_q.size() ? exp_q.pop_front() : 'x);
    if (rd_seen === 1'b1) check(38'(reg_rdata_q), rd_q.size() ? rd_q.pop_front() : 'x);
    if (instr_valid === 1'b1 && instr_word[4:0] == LOW_TABLE) check(38'(table_addr), 38'({pg[AW-9:0], pt}));
  end
  initial begin
    repeat (3000) @(posedge core_clk);
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(68671));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(negedge core_clk);
    check(obs, {LEN_ONE, 36'h0});
    for (int i = 0; i < 32; i++) wrt(6'(i), 10'($urandom));
    wrt(REG_PAGE, 10'($urandom));
    wrt(REG_PTR, 10'($urandom));
    rd(REG_PAGE, {6'h0, pg});
    rd(6'h05, {6'h0, wr[5]});
    rd(6'h3f, 10'h0);
    $display("test registers done");
    for (int i = 0; i < 24; i++) begin
      if (i % 4 == 0) wrt(REG_ACC, 10'($urandom));
      run({i[0] ? GRP_AND : GRP_OR, 1'($urandom), 1'b0, 4'($urandom)}, 10'($urandom), 4'($urandom));
    end
    $display("test register operands done");
    for (int i = 0; i < 16; i++) begin
      wrt(REG_ACC, 10'($urandom));
      if (i % 4 == 0) wrt(i == 8 ? REG_PAGE : REG_PTR, 10'($urandom));
      run(tab[i % 4], 10'($urandom), 4'($urandom));
    end
    $display("test table operands done");
    wrt(REG_ACC, 10'hf);
    for (int i = 0; i < 12; i++) run(i[0] ? 10'h3b1 : 10'h371, {6'h0, 4'($urandom)}, 4'($urandom));
    $display("test immediates done");
    wrt(REG_TIMER, 10'($urandom));
    wrt(REG_MOD_A, 10'($urandom));
    wrt(REG_MOD_B, 10'($urandom));
    rd(REG_TIMER, tm);
    foreach (mv[i]) begin
      if (i % 3 == 0) wrt(REG_ACC, 10'($urandom));
      run(mv[i], 10'($urandom), 4'($urandom));
    end
    $display("test timer loads and moves done");
    for (int i = 0; i < 16; i++) begin
      run(OP_STATUS_TEST_OP_IMM, 10'(i), i[0] ? 4'(i) : 4'($urandom));
      run(10'h060 | 10'(i), 10'h0, i[1] ? wr[i] : 4'($urandom));
    end
    $display("test status done");
    wrt(REG_ACC, 10'hf);
    run(OP_CARRY_SET_IF_ALL_ONES_OP, 10'h0, 4'h0);
    wrt(REG_ACC, 10'he);
    run(OP_CARRY_SET_IF_ALL_ONES_OP, 10'h0, 4'h0);
    run(OP_NOP, 10'h0, 4'h0);
    run(ILL, 10'h0, 4'h0);
    rd(REG_FLAGS, {7'h0, 1'b1, tf, cy});
    wrt(REG_FLAGS, 10'h007);
    rd(REG_FLAGS, {7'h0, 1'b0, tf, cy});
    @(posedge core_clk);
    {instr_valid, reg_rd, reg_wr} <= 3'b000;
    repeat (3) @(posedge core_clk);
    check(38'(exp_q.size() + rd_q.size()), 38'h0);
    $display("test flags and refusal done");
    final_report();
  end
endmodule : tb_top
